// [shared/swps_defs.svh]
// Purpose: constants of the single-wire pullup, speed and status block
// Assumes: core clock of 50 MHz
// Notes: times are in ns, cycle counts are derived from them
`ifndef SWPS_DEFS_SVH
`define SWPS_DEFS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SWPS_CLK_MHZ 50
`define SWPS_CNT_W 12
`define SWPS_SLOT_STD_NS 65000
`define SWPS_SLOT_OD_NS 10000
`define SWPS_APU_NS 2500
`define SWPS_SLOT_STD_CYC ((`SWPS_SLOT_STD_NS * `SWPS_CLK_MHZ) / 1000)
`define SWPS_SLOT_OD_CYC ((`SWPS_SLOT_OD_NS * `SWPS_CLK_MHZ) / 1000)
`define SWPS_APU_CYC ((`SWPS_APU_NS * `SWPS_CLK_MHZ) / 1000)

// ---------------------------------------------------------------
// configuration byte layout
// ---------------------------------------------------------------
`define SWPS_CFG_APU_BIT 0
`define SWPS_CFG_SPU_BIT 2
`define SWPS_CFG_OD_BIT 3
`define SWPS_CFG_RESET 8'h00

// ---------------------------------------------------------------
// status byte layout
// ---------------------------------------------------------------
`define SWPS_ST_BUSY_BIT 0
`define SWPS_ST_PPD_BIT 1
`define SWPS_ST_SD_BIT 2
`define SWPS_ST_LL_BIT 3
`define SWPS_ST_RST_BIT 4
`define SWPS_ST_SBR_BIT 5
`define SWPS_ST_TSB_BIT 6
`define SWPS_ST_DIR_BIT 7

// ---------------------------------------------------------------
// read pointer codes
// ---------------------------------------------------------------
`define SWPS_PTR_CODE_STATUS 8'hF0
`define SWPS_PTR_CODE_DATA 8'hE1
`define SWPS_PTR_CODE_CFG 8'hC3

`endif

// [shared/swps_pkg.sv]
// Purpose: types of the single-wire pullup, speed and status block
// Assumes: nothing
// Notes: one-hot encodings throughout
package swps_pkg;

  typedef enum logic [4:0] {
    SWPS_K_RESET = 5'h01,
    SWPS_K_BIT = 5'h02,
    SWPS_K_WRBYTE = 5'h04,
    SWPS_K_RDBYTE = 5'h08,
    SWPS_K_TRIPLET = 5'h10
  } swps_kind_t;

  typedef enum logic [2:0] {
    SWPS_P_STATUS = 3'h1,
    SWPS_P_DATA = 3'h2,
    SWPS_P_CFG = 3'h4
  } swps_ptr_t;

  typedef struct packed {
    logic cfg_od;
    logic cfg_spu;
    logic cfg_apu;
    logic busy;
    logic presence_seen;
    logic sd;
    logic ll;
    logic rst;
    logic single_bit_result;
    logic triplet_second_bit;
    logic dir;
    swps_kind_t kind;
    swps_ptr_t ptr;
    logic spu_on;
    logic pull_on;
    logic [11:0] apu_cnt;
    logic [11:0] slot_lim;
    logic cfg_ack;
    logic ptr_ack;
  } swps_state_t;

endpackage

// [hdl/swps_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to i_core_clk
// Notes: output follows once stages two and three agree
`timescale 1ns/10ps
module swps_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

endmodule

// [hdl/swps_ctrl.sv]
// Purpose: strong/active pullup control, speed select and status register
// Assumes: command decode and waveform timers sit outside and give pulses
// Notes: all state but the line synchroniser is one struct, registered once per clock
//
// Functional notes
// R1 - strong pullup holds until command, clear, reset
// R2 - external control low exactly while strong pullup
// R3 - strong pullup end clears its config bit
// R4 - start slot rises like active pullup, then holds
// R5 - enabled strong pullup also acts on reset
// R6 - host arms strong pullup just before command
// R7 - speed bit selects slot timing, standard 65us
// R8 - host sets speed right after overdrive command
// R9 - host clears speed then issues bus reset
// R10 - status byte: dir,tsb,sbr,rst,ll,sd,ppd,busy
// R11 - bus and device reset commands point at status
// R12 - busy high throughout bus command, then low
// R13 - presence flag from sample, cleared if short
// R14 - short flag from sample; short forces presence low
// R15 - line level sampled at read-address acknowledge
// R16 - reset flag set by reset, cleared by config
// R17 - single-bit result from read sample, powers 0
// R18 - triplet second bit only on triplets, powers 0
// R19 - direction from triplet third bit, powers 0
// R20 - system disables slave interrupt signalling
// R21 - config accepted only with complemented upper nibble
// R22 - active pullup assists rise for limited time
// R23 - device reset clears speed, active, strong bits
// R24 - untouched flags keep value until updated
`timescale 1ns/10ps
`include "swps_defs.svh"
module swps_ctrl
  import swps_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_line_pin,
  input wire logic i_cmd_dev_reset,
  input wire logic i_cmd_wr_cfg,
  input wire logic [7:0] i_cfg_byte,
  input wire logic i_cmd_set_ptr,
  input wire logic [7:0] i_ptr_code,
  input wire logic i_cmd_bus_start,
  input wire swps_kind_t i_cmd_kind,
  input wire logic i_bus_done,
  input wire logic i_triplet_dir,
  input wire logic i_slot_rise,
  input wire logic i_last_slot,
  input wire logic i_sample_short,
  input wire logic i_sample_presence,
  input wire logic i_sample_read,
  input wire logic i_sample_second,
  input wire logic i_rd_addr_ack,
  output logic [7:0] o_line_status,
  output logic [7:0] o_cfg_rd,
  output swps_ptr_t o_read_ptr,
  output logic o_overdrive_select,
  output logic o_active_pullup_en,
  output logic o_strong_pullup_en,
  output logic [11:0] o_slot_limit,
  output logic o_pullup_on,
  output logic o_ext_pullup_ctl_n,
  output logic o_cfg_ack,
  output logic o_ptr_ack
);

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [11:0] SLOT_STD = 12'(`SWPS_SLOT_STD_CYC);
  localparam logic [11:0] SLOT_OD = 12'(`SWPS_SLOT_OD_CYC);
  localparam logic [11:0] APU_CYC = 12'(`SWPS_APU_CYC);
  localparam logic [7:0] CFG_RST = `SWPS_CFG_RESET;
  localparam swps_state_t RESET_ST = '{
    cfg_od: CFG_RST[`SWPS_CFG_OD_BIT],
    cfg_spu: CFG_RST[`SWPS_CFG_SPU_BIT],
    cfg_apu: CFG_RST[`SWPS_CFG_APU_BIT],
    busy: 1'b0,
    presence_seen: 1'b0,
    sd: 1'b0,
    ll: 1'b1,
    rst: 1'b1,
    single_bit_result: 1'b0,
    triplet_second_bit: 1'b0,
    dir: 1'b0,
    kind: SWPS_K_RESET,
    ptr: SWPS_P_STATUS,
    spu_on: 1'b0,
    pull_on: 1'b0,
    apu_cnt: 12'h000,
    slot_lim: SLOT_STD,
    cfg_ack: 1'b0,
    ptr_ack: 1'b0
  };

  // ---------------------------------------------------------------
  // line input synchroniser
  // ---------------------------------------------------------------
  logic line_lvl;

  swps_sync #(
    .RESET_VAL(1'b1)
  ) u_line_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_line_pin),
    .o_level(line_lvl)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  swps_state_t q;
  swps_state_t d;
  logic cfg_ok;
  logic spu_start;

  always_comb begin
    d = q;
    d.cfg_ack = 1'b0;
    d.ptr_ack = 1'b0;
    cfg_ok = (i_cfg_byte[7:4] == ~i_cfg_byte[3:0]);
    // strong pullup begins on the final rising edge of an armed command
    spu_start = q.busy && i_slot_rise && i_last_slot && q.cfg_spu; // R5

    // active pullup timer, also used for the first part of strong pullup
    if (q.apu_cnt != 12'h000) begin
      d.apu_cnt = q.apu_cnt - 12'h001; // R22
    end
    if (i_slot_rise && (q.cfg_apu || spu_start)) begin
      d.apu_cnt = APU_CYC; // R4
    end
    if (spu_start) begin
      d.spu_on = 1'b1; // R4
    end

    // bus-side samples
    if (q.busy && i_sample_short) begin
      d.sd = ~line_lvl; // R14
      if (!line_lvl) begin
        d.presence_seen = 1'b0; // R14
      end
    end
    if (q.busy && i_sample_presence) begin
      d.presence_seen = ~line_lvl && !d.sd; // R13
    end
    if (q.busy && i_sample_read) begin
      if (i_sample_second && q.kind == SWPS_K_TRIPLET) begin
        d.triplet_second_bit = line_lvl; // R18
      end else begin
        d.single_bit_result = line_lvl; // R17
      end
    end
    if (q.busy && i_bus_done) begin
      d.busy = 1'b0; // R12
      if (q.kind == SWPS_K_TRIPLET) begin
        d.dir = i_triplet_dir; // R19
      end
    end

    // line level snapshot without bus traffic
    if (i_rd_addr_ack && q.ptr == SWPS_P_STATUS) begin
      d.ll = line_lvl; // R15
    end

    // commands from the host engine
    if (i_cmd_set_ptr) begin
      unique case (i_ptr_code)
        `SWPS_PTR_CODE_STATUS: begin
          d.ptr = SWPS_P_STATUS;
          d.ptr_ack = 1'b1;
        end
        `SWPS_PTR_CODE_DATA: begin
          d.ptr = SWPS_P_DATA;
          d.ptr_ack = 1'b1;
        end
        `SWPS_PTR_CODE_CFG: begin
          d.ptr = SWPS_P_CFG;
          d.ptr_ack = 1'b1;
        end
        default: begin
          d.ptr_ack = 1'b0;
        end
      endcase
    end
    if (i_cmd_wr_cfg && !q.busy && cfg_ok) begin
      d.cfg_od = i_cfg_byte[`SWPS_CFG_OD_BIT]; // R21
      d.cfg_spu = i_cfg_byte[`SWPS_CFG_SPU_BIT]; // R21
      d.cfg_apu = i_cfg_byte[`SWPS_CFG_APU_BIT]; // R21
      d.rst = 1'b0; // R16
      d.ptr = SWPS_P_CFG;
      d.cfg_ack = 1'b1;
      if (!i_cfg_byte[`SWPS_CFG_SPU_BIT]) begin
        d.spu_on = 1'b0; // R1
      end
    end
    if (i_cmd_bus_start && !q.busy) begin
      d.busy = 1'b1; // R12
      d.kind = i_cmd_kind;
      d.ptr = SWPS_P_STATUS; // R11
      if (q.spu_on) begin
        d.spu_on = 1'b0; // R1
      end
    end

    // strong pullup end returns its bit to zero
    if (q.spu_on && !d.spu_on) begin
      d.cfg_spu = 1'b0; // R3
    end

    // device reset overrides everything; line level and command kind are left alone
    if (i_cmd_dev_reset) begin
      d.cfg_od = 1'b0; // R23
      d.cfg_spu = 1'b0; // R23
      d.cfg_apu = 1'b0; // R23
      d.spu_on = 1'b0; // R1
      d.apu_cnt = 12'h000;
      d.busy = 1'b0;
      d.presence_seen = 1'b0;
      d.sd = 1'b0;
      d.single_bit_result = 1'b0;
      d.triplet_second_bit = 1'b0;
      d.dir = 1'b0;
      d.rst = 1'b1; // R16
      d.ptr = SWPS_P_STATUS; // R11
      d.cfg_ack = 1'b0;
      d.ptr_ack = 1'b0;
    end

    d.pull_on = d.spu_on || (d.apu_cnt != 12'h000); // R22
    d.slot_lim = d.cfg_od ? SLOT_OD : SLOT_STD; // R7
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= RESET_ST;
    end else begin
      q <= d; // R24
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    o_line_status = {q.dir, q.triplet_second_bit, q.single_bit_result, q.rst, q.ll, q.sd, q.presence_seen, q.busy}; // R10
    o_cfg_rd = {4'h0, q.cfg_od, q.cfg_spu, 1'b0, q.cfg_apu}; // R21
    o_read_ptr = q.ptr;
    o_overdrive_select = q.cfg_od;
    o_active_pullup_en = q.cfg_apu;
    o_strong_pullup_en = q.cfg_spu;
    o_slot_limit = q.slot_lim; // R7
    o_pullup_on = q.pull_on;
    o_ext_pullup_ctl_n = ~q.spu_on; // R2
    o_cfg_ack = q.cfg_ack;
    o_ptr_ack = q.ptr_ack;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_spu_arm;
    q.busy && i_slot_rise && i_last_slot && q.cfg_spu && !i_cmd_dev_reset;
  endsequence

  sequence s_spu_hold;
    !o_ext_pullup_ctl_n && o_pullup_on;
  endsequence

  a_spu_starts: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R4
    s_spu_arm ##0 !i_cmd_bus_start |=> s_spu_hold)
    else $error("strong pullup did not start");

  a_spu_holds: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R1
    !o_ext_pullup_ctl_n && !i_cmd_dev_reset && !i_cmd_bus_start && !i_cmd_wr_cfg
      |=> !o_ext_pullup_ctl_n)
    else $error("strong pullup ended without cause");

  a_ctl_pullup: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R2
    !o_ext_pullup_ctl_n |-> o_pullup_on && o_strong_pullup_en)
    else $error("external control low without strong pullup");

  a_spu_bit_clr: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R3
    $rose(o_ext_pullup_ctl_n) |-> !o_strong_pullup_en
      && (o_active_pullup_en == $past(o_active_pullup_en) || $past(i_cmd_wr_cfg) || $past(i_cmd_dev_reset)))
    else $error("strong pullup bit not cleared at end");

  a_slot_speed: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R7
    o_slot_limit == (o_overdrive_select ? SLOT_OD : SLOT_STD))
    else $error("slot limit does not follow speed");

  a_ptr_status: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R11
    (i_cmd_bus_start && !q.busy) || i_cmd_dev_reset |=> o_read_ptr == SWPS_P_STATUS)
    else $error("pointer not moved to status");

  a_busy_span: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R12
    i_cmd_bus_start && !q.busy && !i_cmd_dev_reset |=> o_line_status[`SWPS_ST_BUSY_BIT])
    else $error("busy not raised by bus command");

  a_busy_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R12
    o_line_status[`SWPS_ST_BUSY_BIT] && !i_bus_done && !i_cmd_dev_reset |=> o_line_status[`SWPS_ST_BUSY_BIT])
    else $error("busy dropped during bus command");

  a_busy_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R12
    o_line_status[`SWPS_ST_BUSY_BIT] && i_bus_done |=> !o_line_status[`SWPS_ST_BUSY_BIT])
    else $error("busy stayed high after completion");

  a_short_ppd: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R14
    o_line_status[`SWPS_ST_SD_BIT] |-> !o_line_status[`SWPS_ST_PPD_BIT])
    else $error("presence set with short");

  a_cfg_reject: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R21
    i_cmd_wr_cfg && !i_cmd_dev_reset && !i_cmd_bus_start && !o_ext_pullup_ctl_n == 1'b0
      && (i_cfg_byte[7:4] != ~i_cfg_byte[3:0]) |=> $stable(o_cfg_rd) && !o_cfg_ack)
    else $error("bad configuration byte accepted");

  a_rst_flag: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R16
    o_cfg_ack |-> !o_line_status[`SWPS_ST_RST_BIT])
    else $error("reset flag survived configuration write");

  a_dev_reset: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R23
    i_cmd_dev_reset |=> o_cfg_rd == 8'h00 && o_line_status[`SWPS_ST_RST_BIT] && o_ext_pullup_ctl_n)
    else $error("device reset left state behind");

endmodule

// [verification/swps_line_model.sv]
// Purpose: far-side model of the single-wire line and its slaves
// Assumes: open-drain line with a resistive pullup
// Notes: a slave pull and a hard short both hold the line low
`timescale 1ns/10ps
module swps_line_model (
  input wire logic i_core_clk,
  input wire logic i_slave_low,
  input wire logic i_short,
  output logic o_line
);
  logic low_q = 1'b0;
  // slaves answer one cycle late, as a real part lags the master
  always_ff @(posedge i_core_clk) begin
    low_q <= i_slave_low;
  end
  // released line rises to the pullup; no slave raises interrupt pulses
  assign o_line = ~(low_q | i_short);
endmodule

// [verification/swps_ctrl_bench.sv]
// Purpose: self-checking bench of the pullup, speed and status block
// Assumes: 50 MHz core clock, inputs driven on the falling edge
// Notes: fixed seed; expectations come from bench functions
`timescale 1ns/10ps
module swps_ctrl_bench;
  import swps_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic slave_low = 1'b0;
  logic short_on = 1'b0;
  logic line, dev_rst, wr_cfg, set_ptr, bstart, bdone, tdir, srise, slast, s_sh, s_pr, s_rd, s_2nd, rd_ack;
  logic [7:0] cfg_b, ptr_c, st, cfg_rd;
  swps_kind_t kind;
  swps_ptr_t rptr;
  logic od, active_pullup_en, strong_pullup_en, pon, ctl_n, cack, pack;
  logic [11:0] slim;
  logic [2:0] v;
  logic [1:0] keep;
  int errors = 0;
  int check_count = 0;
  int seed = 30285;
  int cyc = 0;
  always #10 clk = ~clk;
  swps_line_model i_line (.i_core_clk(clk), .i_slave_low(slave_low), .i_short(short_on), .o_line(line));
  swps_ctrl i_dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_line_pin(line), .i_cmd_dev_reset(dev_rst),
    .i_cmd_wr_cfg(wr_cfg), .i_cfg_byte(cfg_b), .i_cmd_set_ptr(set_ptr), .i_ptr_code(ptr_c),
    .i_cmd_bus_start(bstart), .i_cmd_kind(kind), .i_bus_done(bdone), .i_triplet_dir(tdir),
    .i_slot_rise(srise), .i_last_slot(slast), .i_sample_short(s_sh), .i_sample_presence(s_pr),
    .i_sample_read(s_rd), .i_sample_second(s_2nd), .i_rd_addr_ack(rd_ack), .o_line_status(st),
    .o_cfg_rd(cfg_rd), .o_read_ptr(rptr), .o_overdrive_select(od), .o_active_pullup_en(active_pullup_en),
    .o_strong_pullup_en(strong_pullup_en), .o_slot_limit(slim), .o_pullup_on(pon), .o_ext_pullup_ctl_n(ctl_n),
    .o_cfg_ack(cack), .o_ptr_ack(pack));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] e);
    check_count++;
    if (seen !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one taking edge, then all pulses drop
  task automatic tick;
    @(negedge clk);
    {dev_rst, wr_cfg, set_ptr, bstart, bdone, srise, slast, s_sh, s_pr, s_rd, s_2nd, rd_ack} = '0;
  endtask
  // waits out the model lag and the line synchroniser
  task automatic set_line(input logic lv);
    slave_low = ~lv;
    repeat (6) @(negedge clk);
  endtask
  task automatic start(input swps_kind_t k);
    @(negedge clk);
    bstart = 1'b1;
    kind = k;
    tick;
    chk(st[0], 1'b1);
    chk(12'(rptr), 12'(SWPS_P_STATUS));
  endtask
  task automatic finish_cmd(input logic d);
    @(negedge clk);
    bdone = 1'b1;
    tdir = d;
    tick;
    chk(st[0], 1'b0);
  endtask
  function automatic logic [7:0] cfg_exp(input logic [3:0] n);
    return {4'h0, n[3], n[2], 1'b0, n[0]};
  endfunction
  task automatic cfg(input logic [3:0] n, input logic good);
    logic [7:0] old;
    logic r;
    @(negedge clk);
    old = cfg_rd;
    r = st[4];
    wr_cfg = 1'b1;
    cfg_b = {(good ? ~n : ~n ^ 4'h2), n};
    tick;
    chk(cack, good);
    chk(cfg_rd, good ? cfg_exp(n) : old);
    chk(st[4], good ? 1'b0 : r);
    chk(od, good ? n[3] : old[3]);
    chk(slim, (good ? n[3] : old[3]) ? 12'h1F4 : 12'hCB2);
  endtask
  task automatic ptr(input logic [7:0] code, input logic [2:0] e, input logic ok);
    @(negedge clk);
    set_ptr = 1'b1;
    ptr_c = code;
    tick;
    chk(pack, ok);
    chk(12'(rptr), e);
  endtask
  task automatic ll(input logic lv, input logic upd);
    logic old;
    old = st[3];
    set_line(lv);
    rd_ack = 1'b1;
    tick;
    tick;
    chk(st[3], upd ? lv : old);
  endtask
  task automatic bus_reset(input logic shorted, input logic pres, input logic [1:0] e);
    short_on = shorted;
    set_line(1'b1);
    start(SWPS_K_RESET);
    @(negedge clk);
    s_sh = 1'b1;
    tick;
    set_line(~pres);
    s_pr = 1'b1;
    tick;
    finish_cmd(1'b0);
    chk(st[2:1], e);
  endtask
  task automatic spu_arm(input logic [3:0] n, input swps_kind_t k);
    cfg(n, 1'b1);
    start(k);
    @(negedge clk);
    srise = 1'b1;
    slast = 1'b1;
    tick;
    chk({pon, ctl_n}, 2'h2);
    finish_cmd(1'b0);
    chk(ctl_n, 1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {dev_rst, wr_cfg, set_ptr, bstart, bdone, tdir, srise, slast, s_sh, s_pr, s_rd, s_2nd, rd_ack} = '0;
    cfg_b = 8'h00;
    ptr_c = 8'h00;
    kind = SWPS_K_RESET;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    tick;
    chk(st, 8'h18);
    chk(cfg_rd, 8'h00);
    chk(12'(rptr), 12'(SWPS_P_STATUS));
    chk({pon, ctl_n}, 2'h1);
    $display("test reset done");
    cfg(4'h3, 1'b0);
    cfg(4'hF, 1'b1);
    repeat (12) cfg(4'($random(seed)), 1'($random(seed)));
    cfg(4'hB, 1'b1);
    $display("test config done");
    ptr(8'hE1, 3'h2, 1'b1);
    ptr(8'hC3, 3'h4, 1'b1);
    ptr(8'h5A, 3'h4, 1'b0);
    ptr(8'hF0, 3'h1, 1'b1);
    ptr(8'hE1, 3'h2, 1'b1);
    ll(1'b0, 1'b0);
    @(negedge clk);
    dev_rst = 1'b1;
    tick;
    chk(cfg_rd, 8'h00);
    chk(st & 8'hF7, 8'h10);
    chk(12'(rptr), 12'h001);
    ll(1'b1, 1'b1);
    ll(1'b0, 1'b1);
    $display("test pointer done");
    cfg(4'h1, 1'b1);
    bus_reset(1'b1, 1'b0, 2'h2);
    bus_reset(1'b0, 1'b1, 2'h1);
    bus_reset(1'b0, 1'b0, 2'h0);
    bus_reset(1'b1, 1'b1, 2'h2);
    short_on = 1'b0;
    $display("test bus reset done");
    repeat (6) begin
      v = 3'($random(seed));
      keep = st[7:6];
      set_line(v[0]);
      start(SWPS_K_BIT);
      @(negedge clk);
      s_rd = 1'b1;
      tick;
      finish_cmd(1'b0);
      chk(st[7:5], {keep, v[0]});
      start(SWPS_K_TRIPLET);
      @(negedge clk);
      s_rd = 1'b1;
      tick;
      set_line(v[1]);
      s_rd = 1'b1;
      s_2nd = 1'b1;
      tick;
      finish_cmd(v[2]);
      chk(st[6:5], {v[1], v[0]});
      chk(st[7], v[2]);
    end
    start(SWPS_K_WRBYTE);
    @(negedge clk);
    wr_cfg = 1'b1;
    cfg_b = 8'h78;
    tick;
    chk(cack, 1'b0);
    chk(od, 1'b0);
    finish_cmd(1'b0);
    cfg(4'h9, 1'b1);
    cfg(4'h1, 1'b1);
    bus_reset(1'b0, 1'b0, 2'h0);
    $display("test bit and triplet done");
    set_line(1'b1);
    spu_arm(4'h5, SWPS_K_WRBYTE);
    repeat (200) @(negedge clk);
    chk({pon, ctl_n, strong_pullup_en}, 3'h5);
    start(SWPS_K_BIT);
    chk({ctl_n, strong_pullup_en, active_pullup_en}, 3'h5);
    @(negedge clk);
    srise = 1'b1;
    tick;
    chk(pon, 1'b1);
    repeat (124) @(negedge clk);
    chk(pon, 1'b1);
    @(negedge clk);
    chk(pon, 1'b0);
    finish_cmd(1'b0);
    spu_arm(4'h4, SWPS_K_RESET);
    cfg(4'h0, 1'b1);
    chk({ctl_n, strong_pullup_en}, 2'h2);
    spu_arm(4'h4, SWPS_K_BIT);
    @(negedge clk);
    dev_rst = 1'b1;
    tick;
    chk({ctl_n, strong_pullup_en}, 2'h2);
    $display("test strong pullup done");
    give_verdict;
  end
endmodule
